/* File: testbench/tb_top.sv */
// Purpose: self-checking bench for the setpoint block
// Assumes: a millisecond shortened to 10 clocks
// Notes: register traffic goes through the manager model
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int MS = 10;
	logic clk_i = 1'b0, reset_n_i = 1'b0, run_on_i = 1'b0, ramp_at_zero_i = 1'b0;
	logic [1:0] margin_sel_i = 2'b00;
	logic reg_wr_i, reg_rd_i, reg_rvalid_o, ramp_up_o, ramp_down_o, switches_off_o;
	logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o;
	logic [11:0] target_code_o;
	logic [2:0] load_slope_o, rise_slew_o, fall_slew_o;
	int bad_count = 0, tests_run = 0;
	// 8 ns clock
	always #4 clk_i = ~clk_i;
	vss_setpoint_seq #(.MS_CYCLES(MS)) i_vss_setpoint_seq (.clk_i, .reset_n_i, .reg_wr_i,
		.reg_rd_i, .reg_addr_i, .reg_wdata_i, .reg_rdata_o, .reg_rvalid_o, .run_on_i,
		.margin_sel_i, .ramp_at_zero_i, .target_code_o, .load_slope_o, .ramp_up_o,
		.ramp_down_o, .switches_off_o, .rise_slew_o, .fall_slew_o);
	vss_mgr_model i_m (.clk_i, .reg_wr_o(reg_wr_i), .reg_rd_o(reg_rd_i),
		.reg_addr_o(reg_addr_i), .reg_wdata_o(reg_wdata_i), .reg_rdata_i(reg_rdata_o));
	task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			bad_count++;
			$display("Error %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic wrap_up;
		if (bad_count == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// clocks until a level rises, capped so a hang shows as a bad count
	task automatic wait_hi(ref logic s, output int n);
		n = 0;
		while (s !== 1'b1 && n < 900) begin
			@(negedge clk_i);
			n++;
		end
	endtask
	task automatic settle;
		repeat (4) @(negedge clk_i);
	endtask
	// reset values, delay field width, unmapped read, load slope codes
	task automatic t_regs;
		logic [7:0] b;
		i_m.get(8'h06, b);
		cmp(b, 8'h0B);
		cmp(switches_off_o, 1'b1);
		i_m.put(8'h06, 8'hFF);
		i_m.get(8'h06, b);
		cmp(b, 8'h3F);
		i_m.get(8'h40, b);
		cmp(b, 8'h00);
		for (int k = 0; k < 8; k++) begin
			i_m.put(8'h08, k[7:0]);
			settle();
			cmp(load_slope_o, k[2:0]);
		end
	endtask
	// three setpoints, margin select, shadow held until the lower byte
	task automatic t_points;
		logic [15:0] v;
		logic [15:0] r;
		for (int i = 0; i < 3; i++) begin
			v = 16'h4C75 + 16'h1110 * i[15:0];
			i_m.put16(8'h0B + 8'h02 * i[7:0], v);
			i_m.get16(8'h0B + 8'h02 * i[7:0], r);
			cmp(r, v);
			@(posedge clk_i) margin_sel_i <= i[1:0];
			settle();
			cmp(target_code_o, v[15:4]);
		end
		@(posedge clk_i) margin_sel_i <= 2'b11;
		settle();
		cmp(target_code_o, 12'h4C7);
		@(posedge clk_i) margin_sel_i <= 2'b00;
		i_m.put(8'h0B, 8'h77);
		settle();
		cmp(target_code_o, 12'h4C7);
		i_m.get16(8'h0B, r);
		cmp(r, 16'h4C75);
		i_m.put(8'h0C, 8'h50);
		settle();
		cmp(target_code_o, 12'h775);
	endtask
	// turn on after 2 ms, live setpoint change, timed turn-off
	task automatic t_seq(input logic [7:0] tc, input logic [7:0] turn_off_delay_reg, input int lo);
		int n;
		i_m.put(8'h03, tc);
		i_m.put(8'h05, 8'h02);
		i_m.put(8'h06, turn_off_delay_reg);
		@(posedge clk_i) run_on_i <= 1'b1;
		wait_hi(ramp_up_o, n);
		cmp(n >= 2 * MS && n <= 2 * MS + 10, 1'b1);
		cmp(fall_slew_o, tc[2:0]);
		cmp(rise_slew_o, tc[6:4]);
		i_m.put16(8'h0B, 16'h1900);
		settle();
		cmp({ramp_up_o, target_code_o}, 13'h1190);
		@(posedge clk_i) run_on_i <= 1'b0;
		if (tc[3]) begin
			wait_hi(ramp_down_o, n);
			cmp(n >= lo && n <= lo + 10, 1'b1);
			cmp(switches_off_o, 1'b0);
			@(posedge clk_i) ramp_at_zero_i <= 1'b1;
			lo = 0;
		end
		wait_hi(switches_off_o, n);
		cmp(n >= lo && n <= lo + 10, 1'b1);
		@(posedge clk_i) ramp_at_zero_i <= 1'b0;
	endtask
	// reset, then each scenario in turn
	initial begin
		repeat (12) @(posedge clk_i);
		reset_n_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		t_regs();
		t_points();
		t_seq(8'h44, 8'h01, MS);
		t_seq(8'h4E, 8'h05, 4 * MS);
		wrap_up();
	end
	// watchdog far beyond the expected run
	initial begin
		#200us;
		bad_count++;
		wrap_up();
	end
endmodule

/* File: testbench/vss_mgr_model.sv */
// Purpose: power manager model driving byte register cycles
// Assumes: strobe taken at a rising edge, answer one cycle later
// Notes: idle address and data are inverted so stale values never match
module vss_mgr_model (
	// clock
	input wire logic clk_i,
	// register port
	output logic reg_wr_o = 1'b0,
	output logic reg_rd_o = 1'b0,
	output logic [7:0] reg_addr_o = 8'h00,
	output logic [7:0] reg_wdata_o = 8'h00,
	input wire logic [7:0] reg_rdata_i
);
	// one write, then a quiet cycle
	task automatic put(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		reg_wr_o <= 1'b1;
		reg_addr_o <= a;
		reg_wdata_o <= d;
		@(posedge clk_i);
		reg_wr_o <= 1'b0;
		reg_addr_o <= ~a;
		reg_wdata_o <= ~d;
	endtask
	// one read, data taken once the answer has settled
	task automatic get(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_i);
		reg_rd_o <= 1'b1;
		reg_addr_o <= a;
		@(posedge clk_i);
		reg_rd_o <= 1'b0;
		reg_addr_o <= ~a;
		@(negedge clk_i);
		d = reg_rdata_i;
	endtask
	// upper byte first, so the lower write commits
	task automatic put16(input logic [7:0] a, input logic [15:0] v);
		put(a, v[15:8]);
		put(a + 8'h01, v[7:0]);
	endtask
	task automatic get16(input logic [7:0] a, output logic [15:0] v);
		get(a, v[15:8]);
		get(a + 8'h01, v[7:0]);
	endtask
endmodule

/* File: testbench/vss_seq_chk_assertions.sv */
// Purpose: port checker for the setpoint block
// Assumes: one clock, active-low reset
// Notes: bound below the module
module vss_seq_chk (
	// clock, reset and register port
	input wire logic clk_i, reset_n_i, reg_wr_i, reg_rd_i, reg_rvalid_o,
	input wire logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o,
	// run control and regulator side
	input wire logic run_on_i, ramp_at_zero_i, ramp_up_o, ramp_down_o, switches_off_o,
	input wire logic [1:0] margin_sel_i,
	input wire logic [11:0] target_code_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);
	// first setpoint, upper then lower byte
	sequence up_wr;
		reg_wr_i && reg_addr_i == 8'h0B;
	endsequence
	sequence lo_wr;
		reg_wr_i && reg_addr_i == 8'h0C && margin_sel_i == 2'b00;
	endsequence
	// upper byte, a quiet cycle, lower byte, nominal still selected
	sequence pair_wr;
		up_wr ##1 !reg_wr_i ##1 lo_wr ##1 margin_sel_i == 2'b00;
	endsequence
	property commit_p;
		pair_wr |=> target_code_o == {$past(reg_wdata_i, 4), $past(reg_wdata_i[7:4], 2)};
	endproperty
	read_answer_a: assert property (reg_rd_i |=> reg_rvalid_o)
		else $error("read not answered");
	dof_top_a: assert property (reg_rd_i && reg_addr_i == 8'h06 |=> reg_rdata_o[7:6] == 2'b00)
		else $error("delay top bits set");
	unmapped_read_a: assert property (reg_rd_i && reg_addr_i == 8'h40 |=> reg_rdata_o == 8'h00)
		else $error("unmapped read not zero");
	shadow_only_a: assert property (up_wr ##1 (!reg_wr_i && $stable(margin_sel_i)) |=> $stable(target_code_o))
		else $error("upper byte leaked");
	setpoint_commit_a: assert property (commit_p)
		else $error("setpoint not committed");
	switch_excl_a: assert property (!(switches_off_o && (ramp_up_o || ramp_down_o)))
		else $error("switches off while driving");
	on_wait_a: assert property ($rose(run_on_i) && switches_off_o |=> !ramp_up_o [*5])
		else $error("ramp up too early");
	zero_off_a: assert property (ramp_down_o && ramp_at_zero_i |-> ##[1:4] switches_off_o)
		else $error("no switch off at zero");
endmodule
bind vss_setpoint_seq vss_seq_chk i_vss_seq_chk (.clk_i, .reset_n_i, .reg_wr_i, .reg_rd_i,
	.reg_rvalid_o, .reg_addr_i, .reg_wdata_i, .reg_rdata_o, .run_on_i, .ramp_at_zero_i,
	.ramp_up_o, .ramp_down_o, .switches_off_o, .margin_sel_i, .target_code_o);

/* File: verilog/vss_map.vh */
// Purpose: register offsets, fields, reset values and timing counts
// Assumes: byte-wide register port, 125 MHz clock
// Notes: included by the setpoint block and its delay timer
`ifndef VSS_MAP_VH
`define VSS_MAP_VH
`define VSS_ADDR_TC 8'h03
`define VSS_ADDR_DON 8'h05
`define VSS_ADDR_DOF 8'h06
`define VSS_ADDR_CLS 8'h08
`define VSS_ADDR_SP1_UP 8'h0B
`define VSS_ADDR_SP1_LO 8'h0C
`define VSS_ADDR_SP2_UP 8'h0D
`define VSS_ADDR_SP2_LO 8'h0E
`define VSS_ADDR_SP3_UP 8'h0F
`define VSS_ADDR_SP3_LO 8'h10
`define VSS_DOF_MSB 5
`define VSS_DOF_RST 6'h0B
`define VSS_DON_RST 8'h00
`define VSS_TC_RST 7'h1C
`define VSS_CLS_RST 8'h00
`define VSS_SP_RST 16'h0000
`define VSS_TC_FALL_EN 3
`define VSS_CLS_SLOPE_MSB 2
`define VSS_MS_NS 1000000
`define VSS_CLK_NS 8
`define VSS_MS_CYC (`VSS_MS_NS / `VSS_CLK_NS)
`define VSS_STEP_UV 2500
`define VSS_RAMP_STEP_UV 10000
`endif

/* File: verilog/vss_ms_timer.v */
// Purpose: millisecond tick divider and millisecond down counter
// Assumes: load pulse starts a count, tick is a one-cycle enable
// Notes: done pulses one cycle when the count has run out
`include "vss_map.vh"
module vss_ms_timer #(
	parameter MS_CYCLES = `VSS_MS_CYC
) (
	// clock and reset
	input wire clk_i,
	input wire rst_n_i,
	// control
	input wire load_i,
	input wire [15:0] count_i,
	input wire abort_i,
	// status
	output reg busy_o,
	output reg done_o
);
	reg [31:0] div_q;
	reg [15:0] cnt_q;
	wire tick;

	assign tick = (div_q == (MS_CYCLES - 1));

	// divider held at zero while idle, restarted on load so the first ms is whole
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			div_q <= 32'h00000000;
			cnt_q <= 16'h0000;
			busy_o <= 1'b0;
			done_o <= 1'b0;
		end else begin
			done_o <= 1'b0;
			if (load_i || tick || !busy_o)
				div_q <= 32'h00000000;
			else
				div_q <= div_q + 32'h00000001;
			if (abort_i) begin
				busy_o <= 1'b0;
			end else if (load_i) begin
				cnt_q <= count_i;
				busy_o <= (count_i != 16'h0000);
				done_o <= (count_i == 16'h0000);
			end else if (busy_o && tick) begin
				cnt_q <= cnt_q - 16'h0001;
				if (cnt_q == 16'h0001) begin
					busy_o <= 1'b0;
					done_o <= 1'b1;
				end
			end
		end
	end
endmodule

/* File: verilog/vss_setpoint_seq.v */
// Purpose: output setpoint registers, load slope select and on/off sequencing
// Assumes: byte register port driven by the power manager link decoder
// Notes: turn-on delay field coded in ms here; fall slew code also sets the ramp time subtracted from the turn-off wait
//
// Overview of operation
// - setpoint range 0.7 V to 5.5 V, uniform step
// - three setpoints: nominal, low margin, high margin
// - upper write shadows; lower write commits the shadow and lower byte to its own setpoint only
// - 12-bit code left aligned, 2.5 mV step
// - setpoint pairs at 0x0B through 0x10
// - all setpoint bytes readable and writable
// - committed setpoint applies at once while running
// - eight load slope settings via current-limit register
// - turn-on waits programmed delay before ramp up
// - slewed turn-off delay ends at zero output
// - unslewed turn-off opens both switches at expiry
// - pre-ramp wait equals delay minus ramp time
// - turn-off delay bits 5:0 in whole ms
// - turn-off delay bits 7:6 read zero
// - turn-off delay resets to 11 ms
`include "vss_map.vh"
module vss_setpoint_seq #(
	parameter MS_CYCLES = `VSS_MS_CYC
) (
	// clock and reset
	input wire clk_i,
	input wire reset_n_i,
	// register port
	input wire reg_wr_i,
	input wire reg_rd_i,
	input wire [7:0] reg_addr_i,
	input wire [7:0] reg_wdata_i,
	output reg [7:0] reg_rdata_o,
	output reg reg_rvalid_o,
	// run control
	input wire run_on_i,
	input wire [1:0] margin_sel_i,
	input wire ramp_at_zero_i,
	// regulator controls
	output reg [11:0] target_code_o,
	output reg [2:0] load_slope_o,
	output reg ramp_up_o,
	output reg ramp_down_o,
	output reg switches_off_o,
	output reg [2:0] rise_slew_o,
	output reg [2:0] fall_slew_o
);
	localparam ST_OFF = 5'h01;
	localparam ST_ON_DLY = 5'h02;
	localparam ST_RUN = 5'h04;
	localparam ST_OFF_WAIT = 5'h08;
	localparam ST_OFF_RAMP = 5'h10;

	reg rst_s1_q, rst_n_q;
	reg [15:0] sp1_q, sp2_q, sp3_q;
	reg [7:0] shadow_q;
	reg [7:0] don_q;
	reg [5:0] dof_q;
	reg [6:0] tc_q;
	reg [7:0] cls_q;
	reg [4:0] st_q;
	reg [4:0] st_d;
	reg on_s1_q, on_s2_q, on_s3_q, on_q;
	reg load_d;
	reg [15:0] count_d;
	wire tmr_busy, tmr_done;
	wire [15:0] sel_sp;
	wire [15:0] ramp_ms;
	wire [15:0] dof_ms;

	// fall rate in mV per ms for each slew code
	function [11:0] fall_mv_per_ms;
		input [2:0] code;
		begin
			case (code)
			3'h0: fall_mv_per_ms = 12'h032;
			3'h1: fall_mv_per_ms = 12'h064;
			3'h2: fall_mv_per_ms = 12'h0C8;
			3'h3: fall_mv_per_ms = 12'h0FA;
			3'h4: fall_mv_per_ms = 12'h1F4;
			3'h5: fall_mv_per_ms = 12'h3E8;
			3'h6: fall_mv_per_ms = 12'h7D0;
			default: fall_mv_per_ms = 12'h1F4; // reserved code kept at a safe mid rate
			endcase
		end
	endfunction

	// ramp time in ms, rounded up, from 2.5 mV code steps
	function [15:0] ramp_time_ms;
		input [11:0] code;
		input [2:0] slew;
		reg [31:0] uv;
		reg [31:0] rate;
		reg [31:0] ms;
		begin
			uv = code * `VSS_STEP_UV;
			rate = fall_mv_per_ms(slew) * 32'h000003E8;
			ms = (uv + rate - 32'h00000001) / rate;
			// largest code at slowest rate stays far below 16 bits
			ramp_time_ms = ms[15:0];
		end
	endfunction

	// reset release through two flops
	always @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rst_s1_q <= 1'b0;
			rst_n_q <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_n_q <= rst_s1_q;
		end
	end

	// run command crosses from the pin domain; counts when stages 2 and 3 agree
	always @(posedge clk_i or negedge rst_n_q) begin
		if (!rst_n_q) begin
			on_s1_q <= 1'b0;
			on_s2_q <= 1'b0;
			on_s3_q <= 1'b0;
			on_q <= 1'b0;
		end else begin
			on_s1_q <= run_on_i;
			on_s2_q <= on_s1_q;
			on_s3_q <= on_s2_q;
			if (on_s2_q == on_s3_q)
				on_q <= on_s3_q;
		end
	end

	// register writes; setpoints commit as one 16-bit word
	always @(posedge clk_i or negedge rst_n_q) begin
		if (!rst_n_q) begin
			sp1_q <= `VSS_SP_RST;
			sp2_q <= `VSS_SP_RST;
			sp3_q <= `VSS_SP_RST;
			shadow_q <= 8'h00;
			don_q <= `VSS_DON_RST;
			dof_q <= `VSS_DOF_RST;
			tc_q <= `VSS_TC_RST;
			cls_q <= `VSS_CLS_RST;
		end else if (reg_wr_i) begin
			case (reg_addr_i)
			`VSS_ADDR_SP1_UP, `VSS_ADDR_SP2_UP, `VSS_ADDR_SP3_UP:
				shadow_q <= reg_wdata_i;
			`VSS_ADDR_SP1_LO: sp1_q <= {shadow_q, reg_wdata_i};
			`VSS_ADDR_SP2_LO: sp2_q <= {shadow_q, reg_wdata_i};
			`VSS_ADDR_SP3_LO: sp3_q <= {shadow_q, reg_wdata_i};
			`VSS_ADDR_DON: don_q <= reg_wdata_i;
			`VSS_ADDR_DOF: dof_q <= reg_wdata_i[`VSS_DOF_MSB:0];
			`VSS_ADDR_TC: tc_q <= reg_wdata_i[6:0];
			`VSS_ADDR_CLS: cls_q <= reg_wdata_i;
			default: shadow_q <= shadow_q;
			endcase
		end
	end

	// reads return committed words; unmapped reads give zero
	always @(posedge clk_i or negedge rst_n_q) begin
		if (!rst_n_q) begin
			reg_rdata_o <= 8'h00;
			reg_rvalid_o <= 1'b0;
		end else begin
			reg_rvalid_o <= reg_rd_i;
			if (reg_rd_i) begin
				case (reg_addr_i)
				`VSS_ADDR_SP1_UP: reg_rdata_o <= sp1_q[15:8];
				`VSS_ADDR_SP1_LO: reg_rdata_o <= sp1_q[7:0];
				`VSS_ADDR_SP2_UP: reg_rdata_o <= sp2_q[15:8];
				`VSS_ADDR_SP2_LO: reg_rdata_o <= sp2_q[7:0];
				`VSS_ADDR_SP3_UP: reg_rdata_o <= sp3_q[15:8];
				`VSS_ADDR_SP3_LO: reg_rdata_o <= sp3_q[7:0];
				`VSS_ADDR_DON: reg_rdata_o <= don_q;
				`VSS_ADDR_DOF: reg_rdata_o <= {2'b00, dof_q};
				`VSS_ADDR_TC: reg_rdata_o <= {1'b0, tc_q};
				`VSS_ADDR_CLS: reg_rdata_o <= cls_q;
				default: reg_rdata_o <= 8'h00;
				endcase
			end
		end
	end

	// margin select: 1 low margin, 2 high margin, else nominal
	assign sel_sp = (margin_sel_i == 2'b01) ? sp2_q :
		(margin_sel_i == 2'b10) ? sp3_q : sp1_q;

	// ramp time and pre-ramp wait; a shortfall clamps the wait to zero
	assign ramp_ms = ramp_time_ms(sel_sp[15:4], tc_q[2:0]);
	assign dof_ms = {10'h000, dof_q};

	// sequencing state machine
	always @* begin
		st_d = st_q;
		load_d = 1'b0;
		count_d = 16'h0000;
		case (st_q)
		ST_OFF: begin
			if (on_q) begin
				st_d = ST_ON_DLY;
				load_d = 1'b1;
				count_d = {8'h00, don_q};
			end
		end
		ST_ON_DLY: begin
			if (!on_q)
				st_d = ST_OFF;
			else if (tmr_done)
				st_d = ST_RUN;
		end
		ST_RUN: begin
			if (!on_q) begin
				st_d = ST_OFF_WAIT;
				load_d = 1'b1;
				if (tc_q[`VSS_TC_FALL_EN] && (dof_ms > ramp_ms))
					count_d = dof_ms - ramp_ms;
				else if (tc_q[`VSS_TC_FALL_EN])
					count_d = 16'h0000;
				else
					count_d = dof_ms;
			end
		end
		ST_OFF_WAIT: begin
			if (tmr_done)
				st_d = tc_q[`VSS_TC_FALL_EN] ? ST_OFF_RAMP : ST_OFF;
		end
		ST_OFF_RAMP: begin
			if (ramp_at_zero_i)
				st_d = ST_OFF;
		end
		default: st_d = ST_OFF;
		endcase
	end

	vss_ms_timer #(
		.MS_CYCLES(MS_CYCLES)
	) u_timer (
		.clk_i(clk_i),
		.rst_n_i(rst_n_q),
		.load_i(load_d),
		.count_i(count_d),
		.abort_i(st_q == ST_ON_DLY && !on_q),
		.busy_o(tmr_busy),
		.done_o(tmr_done)
	);

	// state and registered regulator outputs
	always @(posedge clk_i or negedge rst_n_q) begin
		if (!rst_n_q) begin
			st_q <= ST_OFF;
			target_code_o <= 12'h000;
			load_slope_o <= 3'h0;
			ramp_up_o <= 1'b0;
			ramp_down_o <= 1'b0;
			switches_off_o <= 1'b1;
			rise_slew_o <= 3'h0;
			fall_slew_o <= 3'h0;
		end else begin
			st_q <= st_d;
			target_code_o <= sel_sp[15:4];
			load_slope_o <= cls_q[`VSS_CLS_SLOPE_MSB:0];
			rise_slew_o <= tc_q[6:4];
			fall_slew_o <= tc_q[2:0];
			ramp_up_o <= (st_d == ST_RUN) || (st_d == ST_OFF_WAIT);
			ramp_down_o <= (st_d == ST_OFF_RAMP);
			switches_off_o <= (st_d == ST_OFF) || (st_d == ST_ON_DLY);
		end
	end
endmodule
